// ==== exception_map.vh ====
// Purpose: Constants for the exception entry sequencer.
// Assumes: 32-bit data, 8-bit register address, 16-bit status word.
// Notes:   Register offsets are byte addresses on the plain register port.
`ifndef EXCEPTION_MAP_VH
`define EXCEPTION_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_SR        8'h00
`define REG_VTB       8'h04
`define REG_TSP       8'h08
`define REG_IRQSP     8'h0c
`define REG_STAT      8'h10
`define REG_MASK      8'h14
`define REG_INFO      8'h18
`define REG_PC        8'h1c

// ----------------------------------------------------------------------
// Status word fields and reset values
// ----------------------------------------------------------------------
`define TRACE_CONTROL_BITS      15
`define TRACE_CONTROL_BITS_LOW  14
`define PRIVILEGE_LEVEL_BIT     13
`define TASK_REGION_BIT         12
`define IPL_HI                  10
`define IPL_LO                  8
`define SR_RST                  16'h2700
`define IPL_MAX                 3'h7

// ----------------------------------------------------------------------
// Vectors, frame formats, frame lengths in longwords
// ----------------------------------------------------------------------
`define VEC_RESET_SP  8'h00
`define VEC_RESET_PC  8'h01
`define VEC_BUSERR    8'h02
`define VEC_SPURIOUS  8'h18
`define FMT_SHORT     4'h0
`define FMT_THROW     4'h1
`define FMT_SIX       4'h2
`define FMT_FAULT     4'ha
`define LONGS_SHORT   4'h2
`define LONGS_SIX     4'h3
`define LONGS_FAULT   4'h8
`define IACK_ADDR_HI  28'hfffffff

// ----------------------------------------------------------------------
// Event bits in the status register
// ----------------------------------------------------------------------
`define EV_START      0
`define EV_DONE       1
`define EV_HALT       2
`define EV_SPUR       3
`define EV_W          4
`define STAT_RST      4'h0
`define MASK_RST      4'h0

`endif

// ==== exception_entry_sequencer.v ====
// Purpose: Exception entry sequencer of the processor micromachine.
// Assumes: Bus controller and micromachine run on sys_clk; pins do not.
// Notes:   Requests are only taken while idle (a reset also while halted), so a sequence is atomic.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "exception_map.vh"

module exception_entry_sequencer
(
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    output reg         irq,
    input  wire [2:0]  ipl_n,
    input  wire        berr_n,
    input  wire        rst_req_n,
    input  wire        exc_req,
    input  wire [7:0]  exc_vec,
    input  wire        exc_six,
    input  wire [31:0] exc_instr_addr,
    input  wire        cop_req,
    input  wire [7:0]  cop_vec,
    input  wire [31:0] cur_pc,
    input  wire [31:0] fault_addr,
    output reg         exc_ack,
    output reg         busy,
    output reg  [15:0] sr_o,
    output reg  [31:0] new_pc,
    output reg         resume,
    output reg         bus_req,
    output reg         bus_we,
    output reg         bus_iack,
    output reg  [31:0] bus_addr,
    output reg  [31:0] bus_wdata,
    input  wire        bus_ack,
    input  wire        bus_fault,
    input  wire [31:0] bus_rdata
);

// ----------------------------------------------------------------------
// States and kinds
// ----------------------------------------------------------------------
localparam [3:0] ST_IDLE   = 4'h0;
localparam [3:0] ST_SNAP   = 4'h1;
localparam [3:0] ST_IACK   = 4'h2;
localparam [3:0] ST_PREP   = 4'h3;
localparam [3:0] ST_PUSH   = 4'h4;
localparam [3:0] ST_RSTSP  = 4'h5;
localparam [3:0] ST_VREAD  = 4'h6;
localparam [3:0] ST_RESUME = 4'h7;
localparam [3:0] ST_HALT   = 4'h8;

localparam [1:0] K_RST  = 2'h0;
localparam [1:0] K_BERR = 2'h1;
localparam [1:0] K_INT  = 2'h2;
localparam [1:0] K_IRQ  = 2'h3;

// ----------------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------------
reg [4:0] pin_s1_r;
reg [4:0] pin_s2_r;
reg [1:0] pin_s3_r;

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        pin_s1_r <= 5'h1f;
        pin_s2_r <= 5'h1f;
        pin_s3_r <= 2'h3;
    end
    else
    begin
        pin_s1_r <= {rst_req_n, berr_n, ipl_n};
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r[4:3];
    end
end

wire [2:0] ipl_lvl  = ~pin_s2_r[2:0];
wire       berr_edg = pin_s3_r[0] & ~pin_s2_r[3];
wire       rst_edg  = pin_s3_r[1] & ~pin_s2_r[4];

// ----------------------------------------------------------------------
// State registers
// ----------------------------------------------------------------------
reg [3:0]  state_r;
reg [1:0]  kind_r;
reg [15:0] sr_r;
reg [15:0] sr_copy_r;
reg [31:0] vtb_r;
reg [31:0] tsp_r;
reg [31:0] irqsp_r;
reg [3:0]  stat_r;
reg [3:0]  mask_r;
reg [7:0]  vec_r;
reg [3:0]  fmt_r;
reg [3:0]  nlong_r;
reg [3:0]  idx_r;
reg [31:0] base_r;
reg [31:0] pc_save_r;
reg [31:0] aux_r;
reg [2:0]  lvl_r;
reg        second_r;
reg        rst_pend_r;
reg        berr_pend_r;

// Frame layout per longword index
function [31:0] frame_long;
    input [3:0]  idx;
    input [15:0] sr_c;
    input [31:0] pc;
    input [3:0]  fmt;
    input [7:0]  vec;
    input [31:0] aux;
    begin
        case (idx)
            4'h0:    frame_long = {sr_c, pc[31:16]};
            4'h1:    frame_long = {pc[15:0], fmt, 2'b00, vec, 2'b00};
            4'h2:    frame_long = aux;
            default: frame_long = 32'h0000_0000;
        endcase
    end
endfunction

// Vector slot address
function [31:0] vec_addr;
    input [31:0] base;
    input [7:0]  vec;
    begin
        vec_addr = base + {22'h000000, vec, 2'b00};
    end
endfunction

wire irq_pend = (ipl_lvl > sr_r[`IPL_HI:`IPL_LO]);
wire idle_req = rst_pend_r | berr_pend_r | cop_req | exc_req | irq_pend;
wire bus_done = bus_req & bus_ack;
wire [3:0] ev_set;
reg  [3:0] ev_r;

assign ev_set = ev_r;

// ----------------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------------
always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        state_r     <= ST_IDLE;
        kind_r      <= K_RST;
        sr_r        <= `SR_RST;
        sr_copy_r   <= `SR_RST;
        vtb_r       <= 32'h0000_0000;
        tsp_r       <= 32'h0000_0000;
        irqsp_r     <= 32'h0000_0000;
        vec_r       <= 8'h00;
        fmt_r       <= 4'h0;
        nlong_r     <= 4'h0;
        idx_r       <= 4'h0;
        base_r      <= 32'h0000_0000;
        pc_save_r   <= 32'h0000_0000;
        aux_r       <= 32'h0000_0000;
        lvl_r       <= 3'h0;
        second_r    <= 1'b0;
        rst_pend_r  <= 1'b1;
        berr_pend_r <= 1'b0;
        ev_r        <= 4'h0;
        exc_ack     <= 1'b0;
        busy        <= 1'b0;
        new_pc      <= 32'h0000_0000;
        resume      <= 1'b0;
        bus_req     <= 1'b0;
        bus_we      <= 1'b0;
        bus_iack    <= 1'b0;
        bus_addr    <= 32'h0000_0000;
        bus_wdata   <= 32'h0000_0000;
    end
    else
    begin
        exc_ack <= 1'b0;
        resume  <= 1'b0;
        ev_r    <= 4'h0;
        if (bus_done)
        begin
            bus_req  <= 1'b0;
            bus_we   <= 1'b0;
            bus_iack <= 1'b0;
        end
        if (state_r == ST_IDLE && reg_wr && reg_addr == `REG_SR)
            sr_r <= reg_wdata[15:0];
        if (reg_wr && reg_addr == `REG_VTB)
            vtb_r <= reg_wdata;
        if (reg_wr && reg_addr == `REG_TSP && state_r == ST_IDLE)
            tsp_r <= reg_wdata;
        if (reg_wr && reg_addr == `REG_IRQSP && state_r == ST_IDLE)
            irqsp_r <= reg_wdata;
        case (state_r)
            ST_IDLE, ST_HALT:
            begin
                // Priority: reset, bus error, coprocessor, internal, irq
                if (rst_pend_r || (state_r == ST_IDLE && idle_req))
                begin
                    sr_copy_r <= sr_r;
                    pc_save_r <= cur_pc;
                    busy      <= 1'b1;
                    ev_r[`EV_START] <= 1'b1;
                    state_r   <= ST_SNAP;
                    aux_r     <= 32'h0000_0000;
                    fmt_r     <= `FMT_SHORT;
                    nlong_r   <= `LONGS_SHORT;
                    if (rst_pend_r)
                    begin
                        kind_r <= K_RST;
                        vec_r  <= `VEC_RESET_SP;
                    end
                    else if (berr_pend_r)
                    begin
                        kind_r  <= K_BERR;
                        vec_r   <= `VEC_BUSERR;
                        fmt_r   <= `FMT_FAULT;
                        nlong_r <= `LONGS_FAULT;
                        aux_r   <= fault_addr;
                    end
                    else if (cop_req)
                    begin
                        kind_r  <= K_INT;
                        vec_r   <= cop_vec;
                        exc_ack <= 1'b1;
                    end
                    else if (exc_req)
                    begin
                        kind_r  <= K_INT;
                        vec_r   <= exc_vec;
                        exc_ack <= 1'b1;
                        if (exc_six)
                        begin
                            fmt_r   <= `FMT_SIX;
                            nlong_r <= `LONGS_SIX;
                            aux_r   <= exc_instr_addr;
                        end
                    end
                    else
                    begin
                        kind_r <= K_IRQ;
                        lvl_r  <= ipl_lvl;
                    end
                end
            end
            ST_SNAP:
            begin
                // Only after the copy is held are state bits touched
                sr_r[`PRIVILEGE_LEVEL_BIT]    <= 1'b1;
                sr_r[`TRACE_CONTROL_BITS]     <= 1'b0;
                sr_r[`TRACE_CONTROL_BITS_LOW] <= 1'b0;
                if (kind_r == K_RST)
                begin
                    sr_r[`IPL_HI:`IPL_LO]  <= `IPL_MAX;
                    sr_r[`TASK_REGION_BIT] <= 1'b0;
                    vtb_r    <= 32'h0000_0000;
                    bus_req  <= 1'b1;
                    bus_addr <= vec_addr(32'h0000_0000, `VEC_RESET_SP);
                    state_r  <= ST_RSTSP;
                end
                else if (kind_r == K_IRQ)
                begin
                    sr_r[`IPL_HI:`IPL_LO]  <= lvl_r;
                    sr_r[`TASK_REGION_BIT] <= 1'b0;
                    bus_req  <= 1'b1;
                    bus_iack <= 1'b1;
                    bus_addr <= {`IACK_ADDR_HI, lvl_r, 1'b1};
                    state_r  <= ST_IACK;
                end
                else
                    state_r <= ST_PREP;
            end
            ST_IACK:
            begin
                if (bus_done)
                begin
                    // A faulted acknowledge means nobody answered
                    if (bus_fault)
                    begin
                        vec_r <= `VEC_SPURIOUS;
                        ev_r[`EV_SPUR] <= 1'b1;
                    end
                    else
                        vec_r <= bus_rdata[7:0];
                    state_r <= ST_PREP;
                end
            end
            ST_PREP:
            begin
                idx_r   <= 4'h0;
                second_r <= (kind_r == K_IRQ) &
                            sr_copy_r[`TASK_REGION_BIT];
                if (kind_r != K_IRQ && sr_copy_r[`TASK_REGION_BIT])
                begin
                    base_r <= tsp_r - {26'h0, nlong_r, 2'b00};
                    tsp_r  <= tsp_r - {26'h0, nlong_r, 2'b00};
                end
                else
                begin
                    base_r <= irqsp_r - {26'h0, nlong_r, 2'b00};
                    irqsp_r <= irqsp_r - {26'h0, nlong_r, 2'b00};
                end
                state_r <= ST_PUSH;
            end
            ST_PUSH:
            begin
                if (!bus_req)
                begin
                    bus_req   <= 1'b1;
                    bus_we    <= 1'b1;
                    bus_addr  <= base_r + {26'h0, idx_r, 2'b00};
                    bus_wdata <= frame_long(idx_r, sr_copy_r, pc_save_r,
                                            fmt_r, vec_r, aux_r);
                end
                else if (bus_done)
                begin
                    if (bus_fault)
                    begin
                        ev_r[`EV_HALT] <= 1'b1;
                        state_r <= ST_HALT;
                    end
                    else if (idx_r != nlong_r - 4'h1)
                        idx_r <= idx_r + 4'h1;
                    else if (second_r)
                    begin
                        // Marker frame on the task stack
                        second_r <= 1'b0;
                        idx_r    <= 4'h0;
                        fmt_r    <= `FMT_THROW;
                        nlong_r  <= `LONGS_SHORT;
                        base_r   <= tsp_r - {26'h0, `LONGS_SHORT, 2'b00};
                        tsp_r    <= tsp_r - {26'h0, `LONGS_SHORT, 2'b00};
                    end
                    else
                    begin
                        bus_req  <= 1'b1;
                        bus_addr <= vec_addr(vtb_r, vec_r);
                        state_r  <= ST_VREAD;
                    end
                end
            end
            ST_RSTSP:
            begin
                if (bus_done)
                begin
                    if (bus_fault)
                    begin
                        ev_r[`EV_HALT] <= 1'b1;
                        state_r <= ST_HALT;
                    end
                    else
                    begin
                        irqsp_r  <= bus_rdata;
                        vec_r    <= `VEC_RESET_PC;
                        bus_req  <= 1'b1;
                        bus_addr <= vec_addr(vtb_r, `VEC_RESET_PC);
                        state_r  <= ST_VREAD;
                    end
                end
            end
            ST_VREAD:
            begin
                if (bus_done)
                begin
                    if (bus_fault)
                    begin
                        ev_r[`EV_HALT] <= 1'b1;
                        state_r <= ST_HALT;
                    end
                    else
                    begin
                        new_pc  <= bus_rdata;
                        state_r <= ST_RESUME;
                    end
                end
            end
            ST_RESUME:
            begin
                resume  <= 1'b1;
                busy    <= 1'b0;
                ev_r[`EV_DONE] <= 1'b1;
                state_r <= ST_IDLE;
            end
            default:
                state_r <= ST_IDLE;
        endcase
        // A new edge in the ST_SNAP cycle wins over the clear
        if (rst_edg)
            rst_pend_r <= 1'b1;
        else if (state_r == ST_SNAP && kind_r == K_RST)
            rst_pend_r <= 1'b0;
        if (berr_edg)
            berr_pend_r <= 1'b1;
        else if (state_r == ST_SNAP && kind_r == K_BERR)
            berr_pend_r <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// Register port, events and interrupt line
// ----------------------------------------------------------------------
reg [3:0] stat_nxt;
reg [3:0] mask_nxt;

always @*
begin
    stat_nxt = stat_r;
    if (reg_rd && reg_addr == `REG_STAT)
        stat_nxt = `STAT_RST;
    stat_nxt = stat_nxt | ev_set;
    mask_nxt = mask_r;
    if (reg_wr && reg_addr == `REG_MASK)
        mask_nxt = reg_wdata[`EV_W-1:0];
end

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        stat_r    <= `STAT_RST;
        mask_r    <= `MASK_RST;
        irq       <= 1'b0;
        reg_rdata <= 32'h0000_0000;
        sr_o      <= `SR_RST;
    end
    else
    begin
        stat_r <= stat_nxt;
        mask_r <= mask_nxt;
        irq    <= |(stat_nxt & mask_nxt);
        sr_o   <= sr_r;
        if (reg_rd)
        begin
            case (reg_addr)
                `REG_SR:   reg_rdata <= {16'h0000, sr_r};
                `REG_VTB:  reg_rdata <= vtb_r;
                `REG_TSP:  reg_rdata <= tsp_r;
                `REG_IRQSP: reg_rdata <= irqsp_r;
                `REG_STAT: reg_rdata <= {28'h0, stat_r};
                `REG_MASK: reg_rdata <= {28'h0, mask_r};
                `REG_INFO: reg_rdata <= {12'h0, fmt_r, 2'h0, kind_r,
                                         vec_r, state_r};
                `REG_PC:   reg_rdata <= new_pc;
                default:   reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end
end

endmodule // exception_entry_sequencer
`default_nettype wire

// ==== seq_checker.sv ====
// Purpose: Port checks for the exception entry sequencer
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module seq_checker
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        busy,
    input wire logic        exc_ack,
    input wire logic        resume,
    input wire logic [15:0] sr_o,
    input wire logic        bus_req,
    input wire logic        bus_we,
    input wire logic        bus_iack,
    input wire logic        bus_ack
);
    // --------------------------------------------------------------
    // Vector read seen: no frame write may follow it
    // --------------------------------------------------------------
    logic rd_seen_r;
    logic rd_seen_nxt;
    assign rd_seen_nxt = (resume || !busy) ? 1'b0 :
        (bus_req && bus_ack && !bus_we && !bus_iack) ? 1'b1 : rd_seen_r;
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            rd_seen_r <= 1'b0;
        else
            rd_seen_r <= rd_seen_nxt;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    AST_ACK_BUSY: assert property (exc_ack |-> busy)
        else $error("exc_ack outside a sequence");
    AST_IDLE_BUS: assert property (!busy |-> !bus_req)
        else $error("bus request while idle");
    AST_PRIV: assert property ($rose(busy) |-> ##[1:4] sr_o[13])
        else $error("privilege bit not set on entry");
    AST_TRACE: assert property
        ($rose(busy) |-> ##[1:4] (sr_o[15:14] == 2'b00))
        else $error("trace bits not cleared on entry");
    AST_HOLD: assert property
        (bus_req && !bus_ack |=> bus_req && $stable(bus_we))
        else $error("bus request dropped before ack");
    AST_FRAME_FIRST: assert property
        (rd_seen_r |-> !(bus_req && bus_we))
        else $error("frame write after vector read");
    AST_IACK_READ: assert property (bus_iack |-> bus_req && !bus_we)
        else $error("acknowledge cycle is not a read");
    AST_RESUME: assert property (resume |-> !bus_req ##1 !resume)
        else $error("resume overlaps bus or lasts");
    AST_ACK_PULSE: assert property (exc_ack |=> !exc_ack)
        else $error("exc_ack longer than one cycle");
    C_IACK: cover property (bus_iack && bus_ack);
    C_WRITE: cover property (bus_we && bus_ack);
    C_RESUME: cover property (resume);
endmodule // seq_checker
bind exception_entry_sequencer seq_checker u_chk (.sys_clk, .nrst, .busy,
    .exc_ack, .resume, .sr_o, .bus_req, .bus_we, .bus_iack, .bus_ack);
`default_nettype wire

// ==== bus_mem_model.sv ====
// Purpose: Bus partner: memory plus interrupting peripheral
// Assumes: Answers after lat wait cycles, one ack pulse per cycle
// Notes:   Memory reads return address plus 0x100, acknowledges return iack_vec; every cycle is logged
`timescale 1ns/1ps
`default_nettype none
module bus_mem_model
(
    input  wire logic [1:0]  lat,
    input  wire logic [7:0]  iack_vec,
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        bus_req,
    input  wire logic        bus_we,
    input  wire logic        bus_iack,
    input  wire logic [31:0] bus_addr,
    input  wire logic [31:0] bus_wdata,
    output var  logic        bus_ack,
    output wire logic        bus_fault,
    output var  logic [31:0] bus_rdata
);
    logic [31:0] la [0:63];
    logic [31:0] ld [0:63];
    logic [1:0]  lk [0:63];
    int          n = 0;
    logic [1:0]  cnt_r;
    assign bus_fault = 1'b0;
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bus_ack <= 1'b0;
            cnt_r <= 2'd0;
            bus_rdata <= 32'h0;
        end
        else if (bus_req && !bus_ack && cnt_r == lat)
        begin
            cnt_r <= 2'd0;
            bus_ack <= 1'b1;
            bus_rdata <= bus_iack ? {24'h0, iack_vec} : bus_addr + 32'h100;
            la[n[5:0]] <= bus_addr;
            ld[n[5:0]] <= bus_wdata;
            lk[n[5:0]] <= {bus_iack, bus_we};
            n <= n + 1;
        end
        else
        begin
            // Data no longer held: keep it moving
            bus_ack <= 1'b0;
            bus_rdata <= ~bus_rdata;
            if (bus_req && !bus_ack)
                cnt_r <= cnt_r + 2'd1;
        end
    end
endmodule // bus_mem_model
`default_nettype wire

// ==== tb_exception_entry_sequencer.sv ====
// Purpose: Self-checking bench for the exception entry sequencer
// Assumes: Bus partner logs every cycle it answers
// Notes:   Rows are {kind, vector, six, longs, format}
`timescale 1ns/1ps
`default_nettype none
`include "exception_map.vh"
module tb_exception_entry_sequencer;
    logic        sys_clk, nrst, reg_wr, reg_rd, irq, berr_n, exc_req;
    logic        exc_six, cop_req, exc_ack, busy, resume, bus_req;
    logic        bus_we, bus_iack, bus_ack, bus_fault, rst_req_n;
    logic [1:0]  lat;
    logic [2:0]  ipl_n;
    logic [7:0]  reg_addr, exc_vec, cop_vec, iack_vec;
    logic [15:0] sr_o;
    logic [31:0] reg_wdata, reg_rdata, cur_pc, new_pc, bus_addr;
    logic [31:0] bus_wdata, bus_rdata, va;
    int          n_errors = 0, compares = 0, base, i;
    logic [18:0] rows [0:3] = '{{2'd0, 8'h05, 1'b0, 4'h2, 4'h0},
        {2'd0, 8'h0b, 1'b1, 4'h3, 4'h2}, {2'd1, 8'h37, 1'b0, 4'h2, 4'h0},
        {2'd2, 8'h02, 1'b0, 4'h8, 4'ha}};
    exception_entry_sequencer u_dut (.sys_clk, .nrst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .irq, .ipl_n, .berr_n,
        .rst_req_n, .exc_req, .exc_vec, .exc_six, .cop_req, .cop_vec,
        .exc_instr_addr(32'h0000_1234), .cur_pc, .fault_addr(32'h5678),
        .exc_ack, .busy, .sr_o, .new_pc, .resume, .bus_req, .bus_we,
        .bus_iack, .bus_addr, .bus_wdata, .bus_ack, .bus_fault, .bus_rdata);
    bus_mem_model u_mem (.lat, .iack_vec, .sys_clk, .nrst, .bus_req, .bus_we,
        .bus_iack, .bus_addr, .bus_wdata, .bus_ack, .bus_fault, .bus_rdata);
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wt(ref logic s, input logic v);
        for (int j = 0; j < 400 && s !== v; j++)
            @(posedge sys_clk) #1;
        if (s !== v)
        begin
            n_errors++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, reg_rdata, e);
    endtask
    task automatic setup(input logic [15:0] sr);
        wr(`REG_SR, {16'h0, sr});
        wr(`REG_IRQSP, 32'h400);
        wr(`REG_TSP, 32'h600);
        wr(`REG_VTB, 32'h800);
        base = u_mem.n;
    endtask
    task automatic frame(input int e, input logic [3:0] ln,
        input logic [15:0] sr, input logic [3:0] fm, input logic [7:0] v);
        for (int j = 0; j < ln; j++)
        begin
            chk("frame addr", u_mem.la[e+j], 32'h400 - 4*ln + 4*j);
            chk("frame kind", u_mem.lk[e+j], 2'b01);
        end
        chk("saved status", u_mem.ld[e][31:16], sr);
        chk("saved pc", u_mem.ld[e][15:0], cur_pc[31:16]);
        chk("format", u_mem.ld[e+1], {cur_pc[15:0], fm, 2'b0, v, 2'b0});
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    initial
    begin
        nrst = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
        ipl_n = 3'h7; berr_n = 1; exc_req = 0; exc_six = 0; exc_vec = 0;
        cop_req = 0; cop_vec = 0; cur_pc = 0; lat = 0; iack_vec = 8'h40;
        rst_req_n = 1;
        repeat (12) @(posedge sys_clk);
        #1 chk("reset status", sr_o, `SR_RST);
        base = u_mem.n;
        @(posedge sys_clk) nrst <= 1'b1;
        #1 wt(resume, 1'b1);
        chk("reset pc", new_pc, 32'h104);
        chk("reset no frame", u_mem.n - base, 2);
        wt(busy, 1'b0);
        rd(`REG_IRQSP, 32'h100, "irq sp load");
        rd(8'h20, 32'h0, "unmapped");
        $display("reset done");
        for (i = 0; i < 4; i++)
        begin
            setup(16'hc000);
            lat <= i[1:0];
            cur_pc <= 32'h00ab_0010 + i;
            exc_req <= rows[i][18:17] == 2'd0;
            cop_req <= rows[i][18:17] == 2'd1;
            berr_n <= rows[i][18:17] != 2'd2;
            exc_vec <= rows[i][16:9];
            cop_vec <= rows[i][16:9];
            exc_six <= rows[i][8];
            #1 wt(busy, 1'b1);
            @(posedge sys_clk);
            exc_req <= 1'b0;
            cop_req <= 1'b0;
            berr_n <= 1'b1;
            #1 wt(resume, 1'b1);
            va = 32'h800 + {22'h0, rows[i][16:9], 2'b0};
            frame(base, rows[i][7:4], 16'hc000, rows[i][3:0], rows[i][16:9]);
            chk("vector addr", u_mem.la[base+rows[i][7:4]], va);
            chk("new pc", new_pc, va + 32'h100);
            chk("priv trace", sr_o[15:13], 3'b001);
            if (rows[i][8])
                chk("aux", u_mem.ld[base+2], 32'h0000_1234);
            if (rows[i][3:0] == 4'ha)
                chk("fault aux", u_mem.ld[base+2], 32'h5678);
            wt(busy, 1'b0);
            $display("row %0d done", i);
        end
        rd(`REG_STAT, 32'h3, "events");
        wr(`REG_MASK, 32'h2);
        setup(16'h1000);
        lat <= 2'd1;
        ipl_n <= 3'b010;
        #1 wt(busy, 1'b1);
        @(posedge sys_clk);
        ipl_n <= 3'h7;
        #1 wt(resume, 1'b1);
        chk("iack kind", u_mem.lk[base], 2'b10);
        frame(base + 1, 4'h2, 16'h1000, 4'h0, 8'h40);
        chk("marker sp", u_mem.la[base+3], 32'h5f8);
        chk("marker fmt", u_mem.ld[base+4][15:12], 4'h1);
        chk("irq vector", u_mem.la[base+5], 32'h900);
        chk("task region", sr_o[12], 1'b0);
        chk("irq mask", sr_o[10:8], 3'h5);
        wt(irq, 1'b1);
        rd(`REG_STAT, 32'h3, "irq events");
        wt(irq, 1'b0);
        chk("irq clear", irq, 1'b0);
        $display("interrupt done");
        wr(`REG_SR, 32'h1000);
        rst_req_n <= 1'b0;
        #1 wt(busy, 1'b1);
        @(posedge sys_clk);
        rst_req_n <= 1'b1;
        #1 wt(resume, 1'b1);
        chk("pin rst pc", new_pc, 32'h104);
        chk("pin rst sr", sr_o[13:8], 6'h27);
        rd(`REG_VTB, 32'h0, "base clear");
        $display("pin reset done");
        complete_run();
    end
endmodule // tb_exception_entry_sequencer
`default_nettype wire
